// ===== hbm_pkg.sv
package hbm_pkg;
    localparam int         BURST_SHORT   = 4;
    localparam int         BURST_LONG    = 8;
    localparam int         BEAT_W        = 4;
    localparam int         PAGE_BITS     = 12;
    localparam logic [3:0] FUNC_PTR_MEM  = 4'hf;
    localparam logic       PARITY_ODD    = 1'b1;
    localparam logic [1:0] ACK_HOLDOFF   = 2'h2;
    localparam logic [31:0] AD_RESET     = 32'h0000_0000;
    localparam logic [25:0] WA_RESET     = 26'h000_0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_REQ   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DATA  = 3'b011,
        ST_RECOV = 3'b100
    } hbm_state_t;
endpackage

// ===== hbm_host_bus_master.sv
module hbm_host_bus_master #(
    parameter int PAGE_BITS = hbm_pkg::PAGE_BITS
) (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_reset,
    // transfer request from the channels
    input  wire logic                  i_xfer_req,
    input  wire logic                  i_xfer_write,
    input  wire logic                  i_xfer_long,
    input  wire logic [3:0]            i_xfer_func,
    input  wire logic [27:2]           i_xfer_addr,
    output logic                       o_xfer_busy,
    output logic                       o_xfer_done,
    // data to and from the channels
    input  wire logic [31:0]           i_wr_data,
    output logic                       o_wr_data_take,
    output logic [31:0]                o_rd_data,
    output logic                       o_rd_valid,
    output logic                       o_rd_parity_err,
    // mode settings
    input  wire logic                  i_upper_addr_user_mode,
    input  wire logic [3:0]            i_upper_addr_user_value,
    input  wire logic                  i_word_addr_timing_mode,
    input  wire logic                  i_virtual_mode,
    input  wire logic [27-PAGE_BITS:0] i_page_frame,
    // host bus pins
    output logic                       o_host_bus_request,
    input  wire logic                  i_host_bus_grant,
    input  wire logic                  i_host_bus_acknowledge,
    output logic                       o_host_addr_strobe,
    output logic                       o_host_addr_strobe_oe,
    output logic [31:0]                o_host_addr_data,
    output logic                       o_host_addr_data_oe,
    input  wire logic [31:0]           i_host_addr_data,
    output logic [3:0]                 o_host_byte_parity,
    output logic                       o_host_byte_parity_oe,
    input  wire logic [3:0]            i_host_byte_parity,
    output logic [25:0]                o_host_word_addr,
    output logic                       o_host_word_addr_oe
);
    function automatic logic [3:0] lane_par(input logic [31:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++)
            p[i] = (^d[8*i +: 8]) ^ hbm_pkg::PARITY_ODD;
        return p;
    endfunction

    hbm_pkg::hbm_state_t state_reg;
    hbm_pkg::hbm_state_t state_next;
    logic [1:0]  grant_sync_reg;
    logic [1:0]  ack_sync_reg;
    logic [31:0] ad_s1_reg;
    logic [31:0] ad_s2_reg;
    logic [3:0]  par_s1_reg;
    logic [3:0]  par_s2_reg;
    logic [25:0] base_reg;
    logic [3:0]  upper_reg;
    logic        write_reg;
    logic        long_reg;
    logic        timing_reg;
    logic [hbm_pkg::BEAT_W-1:0] beat_reg;
    logic [1:0]  holdoff_reg;

    wire         grant_s    = grant_sync_reg[1];
    // a grant still in the synchroniser from the last tenure must not start a new one
    wire         grant_ok   = grant_s && (holdoff_reg == 2'h0);
    wire         ack_hit    = ack_sync_reg[1] && (holdoff_reg == 2'h0) && (state_reg == hbm_pkg::ST_DATA);
    wire [hbm_pkg::BEAT_W-1:0] burst_len = long_reg ? hbm_pkg::BEAT_W'(hbm_pkg::BURST_LONG)
                                                    : hbm_pkg::BEAT_W'(hbm_pkg::BURST_SHORT);
    wire         last_beat  = (beat_reg == burst_len - 1'b1);
    // virtual pages keep the offset and take the frame number
    wire [25:0]  phys_addr  = i_virtual_mode
                              ? {i_page_frame, i_xfer_addr[PAGE_BITS-1:2]} : i_xfer_addr;
    wire [3:0]   upper_next = i_upper_addr_user_mode ? i_upper_addr_user_value
                                                     : i_xfer_func;
    wire [25:0]  cur_word   = base_reg + 26'(beat_reg);
    wire         drive_addr = (state_next == hbm_pkg::ST_ADDR);
    wire         drive_wr   = (state_next == hbm_pkg::ST_DATA) && write_reg;
    wire         on_bus     = drive_addr || (state_next == hbm_pkg::ST_DATA);
    wire [31:0]  ad_next    = drive_addr ? {upper_reg, base_reg, 2'b00}
                                         : i_wr_data;
    wire         wa_drive   = (state_next == hbm_pkg::ST_DATA)
                              || (drive_addr && timing_reg)
                              || (state_next == hbm_pkg::ST_RECOV);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            hbm_pkg::ST_IDLE:  if (i_xfer_req) state_next = hbm_pkg::ST_REQ;
            hbm_pkg::ST_REQ:   if (grant_ok) state_next = hbm_pkg::ST_ADDR;
            hbm_pkg::ST_ADDR:  state_next = hbm_pkg::ST_DATA;
            hbm_pkg::ST_DATA:  if (ack_hit && last_beat) state_next = hbm_pkg::ST_RECOV;
            hbm_pkg::ST_RECOV: state_next = hbm_pkg::ST_IDLE;
            default:           state_next = hbm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        grant_sync_reg <= {grant_sync_reg[0], i_host_bus_grant};
        ack_sync_reg   <= {ack_sync_reg[0], i_host_bus_acknowledge};
        ad_s1_reg      <= i_host_addr_data;
        ad_s2_reg      <= ad_s1_reg;
        par_s1_reg     <= i_host_byte_parity;
        par_s2_reg     <= par_s1_reg;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            state_reg   <= hbm_pkg::ST_IDLE;
            base_reg    <= hbm_pkg::WA_RESET;
            upper_reg   <= 4'h0;
            write_reg   <= 1'b0;
            long_reg    <= 1'b0;
            timing_reg  <= 1'b0;
            beat_reg    <= '0;
            holdoff_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == hbm_pkg::ST_IDLE && i_xfer_req)
            begin
                base_reg   <= phys_addr;
                upper_reg  <= upper_next;
                write_reg  <= i_xfer_write;
                long_reg   <= i_xfer_long;
                timing_reg <= i_word_addr_timing_mode;
                beat_reg   <= '0;
            end
            else if (ack_hit)
                beat_reg <= beat_reg + 1'b1;
            // a held acknowledge level must not count twice, and a new request
            // waits until the grant synchroniser has flushed
            holdoff_reg <= (ack_hit || (state_reg == hbm_pkg::ST_IDLE && i_xfer_req))
                           ? hbm_pkg::ACK_HOLDOFF
                           : (holdoff_reg != 2'h0 ? holdoff_reg - 2'h1 : 2'h0);
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            o_xfer_busy           <= 1'b0;
            o_xfer_done           <= 1'b0;
            o_wr_data_take        <= 1'b0;
            o_rd_data             <= hbm_pkg::AD_RESET;
            o_rd_valid            <= 1'b0;
            o_rd_parity_err       <= 1'b0;
            o_host_bus_request    <= 1'b0;
            o_host_addr_strobe    <= 1'b0;
            o_host_addr_strobe_oe <= 1'b0;
            o_host_addr_data      <= hbm_pkg::AD_RESET;
            o_host_addr_data_oe   <= 1'b0;
            o_host_byte_parity    <= 4'h0;
            o_host_byte_parity_oe <= 1'b0;
            o_host_word_addr      <= hbm_pkg::WA_RESET;
            o_host_word_addr_oe   <= 1'b0;
        end
        else
        begin
            o_xfer_busy           <= (state_next != hbm_pkg::ST_IDLE);
            o_xfer_done           <= (state_reg == hbm_pkg::ST_RECOV);
            o_wr_data_take        <= ack_hit && write_reg;
            o_rd_valid            <= ack_hit && !write_reg;
            o_rd_parity_err       <= ack_hit && !write_reg
                                     && (lane_par(ad_s2_reg) != par_s2_reg);
            if (ack_hit && !write_reg)
                o_rd_data <= ad_s2_reg;
            o_host_bus_request    <= (state_next == hbm_pkg::ST_REQ);
            o_host_addr_strobe    <= on_bus;
            o_host_addr_strobe_oe <= on_bus || (state_next == hbm_pkg::ST_RECOV);
            o_host_addr_data      <= ad_next;
            o_host_addr_data_oe   <= drive_addr || drive_wr;
            o_host_byte_parity    <= lane_par(ad_next);
            o_host_byte_parity_oe <= drive_addr || drive_wr;
            o_host_word_addr      <= (state_next == hbm_pkg::ST_RECOV) ? hbm_pkg::WA_RESET
                                     : (drive_addr ? base_reg : cur_word);
            o_host_word_addr_oe   <= wa_drive;
        end
    end

    // assertion helpers
    logic [hbm_pkg::BEAT_W-1:0] acks_seen;
    always_ff @(posedge i_clock)
    begin
        if (i_reset || state_reg == hbm_pkg::ST_ADDR)
            acks_seen <= '0;
        else if (ack_hit)
            acks_seen <= acks_seen + 1'b1;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence last_ack_s;
        ack_hit && last_beat;
    endsequence
    sequence recovery_s;
        ##1 (state_reg == hbm_pkg::ST_RECOV) && !o_host_addr_strobe ##1 !o_host_addr_strobe_oe;
    endsequence

    grant_first_a: assert property ($rose(o_host_addr_data_oe) && o_host_addr_strobe
        |-> $past(grant_s)) else $error("bus driven without grant");
    grant_fresh_a: assert property ($rose(o_host_addr_strobe)
        |-> $past(o_host_bus_request, 3)) else $error("grant taken before request settled");
    burst_count_a: assert property ((state_reg == hbm_pkg::ST_RECOV)
        |-> acks_seen == burst_len) else $error("burst length wrong");
    virt_page_a: assert property ((state_reg == hbm_pkg::ST_REQ) && $past(i_virtual_mode)
        && $past(state_reg == hbm_pkg::ST_IDLE) |-> base_reg[25:PAGE_BITS-2] == $past(i_page_frame))
        else $error("page frame not used");
    lane_parity_a: assert property (o_host_byte_parity_oe
        |-> o_host_byte_parity == lane_par(o_host_addr_data)) else $error("lane parity bad");
    addr_phase_a: assert property ($rose(o_host_addr_strobe)
        |-> o_host_addr_data[27:0] == {base_reg, 2'b00} && o_host_addr_data[31:28] == upper_reg)
        else $error("address phase wrong");
    upper_field_a: assert property ((state_reg == hbm_pkg::ST_IDLE) && i_xfer_req
        && i_upper_addr_user_mode |=> upper_reg == $past(i_upper_addr_user_value))
        else $error("user value lost");
    func_code_a: assert property ((state_reg == hbm_pkg::ST_IDLE) && i_xfer_req
        && !i_upper_addr_user_mode |=> upper_reg == $past(i_xfer_func))
        else $error("function code lost");
    word_recov_a: assert property ((state_reg == hbm_pkg::ST_RECOV)
        |-> o_host_word_addr_oe && o_host_word_addr == 26'h0 ##1 !o_host_word_addr_oe)
        else $error("word address not released");
    word_align_a: assert property (o_host_addr_strobe && !$past(o_host_addr_strobe)
        |-> o_host_addr_data[1:0] == 2'b00) else $error("address not word aligned");
    idle_release_a: assert property (
        (state_reg inside {hbm_pkg::ST_IDLE, hbm_pkg::ST_REQ})
        |-> !o_host_addr_data_oe && !o_host_byte_parity_oe) else $error("bus not released");
    recovery_a: assert property (last_ack_s |-> recovery_s)
        else $error("recovery cycle missing");
    parity_err_a: assert property (ack_hit && !write_reg
        |=> o_rd_parity_err == ($past(lane_par(ad_s2_reg)) != $past(par_s2_reg)))
        else $error("read parity check wrong");
endmodule // hbm_host_bus_master

// ===== hbm_host_model.sv
module hbm_host_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    // master pins
    input  wire logic        i_req,
    input  wire logic        i_strobe,
    input  wire logic        i_strobe_oe,
    input  wire logic [31:0] i_ad,
    input  wire logic [25:0] i_wa,
    // test controls
    input  wire logic [3:0]  i_beats,
    input  wire logic        i_slow,
    input  wire logic        i_bad,
    // host answers
    output logic             o_grant,
    output logic             o_ack,
    output logic [31:0]      o_ad,
    output logic [3:0]       o_par
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] addr_cap;
    logic [31:0] wr_log [8];
    logic [25:0] wa_log [8];
    logic        strobe_d;
    int          beat;
    int          gap;
    function automatic logic [3:0] par4(input logic [31:0] d);
        for (int i = 0; i < 4; i++) par4[i] = ^d[8*i+:8] ^ hbm_pkg::PARITY_ODD;
    endfunction
    always @(posedge i_clock)
    begin
        strobe_d <= i_strobe;
        o_ack <= 1'b0;
        // released lines must not keep their last value
        o_ad <= ~o_ad;
        o_par <= ~o_par;
        if (o_ack)
        begin
            wr_log[beat-1] <= i_ad;
            wa_log[beat-1] <= i_wa;
        end
        if (i_reset)
        begin
            o_grant <= 1'b0;
            o_ad <= 32'h5a5a_5a5a;
            o_par <= 4'h5;
            beat <= 0;
        end
        else
        begin
            o_grant <= i_req | (o_grant & i_strobe_oe);
            if (i_strobe && !strobe_d)
            begin
                addr_cap <= i_ad;
                beat <= 0;
                gap <= i_slow ? 6 : 2;
            end
            else if (i_strobe && beat < int'(i_beats))
            begin
                gap <= gap - 1;
                if (gap == 0)
                begin
                    o_ack <= 1'b1;
                    o_ad <= 32'ha5a5_0000 + beat;
                    o_par <= par4(32'ha5a5_0000 + beat) ^ {3'h0, i_bad};
                    gap <= i_slow ? 6 : 3;
                    beat <= beat + 1;
                end
            end
        end
    end
endmodule // hbm_host_model

// ===== hbm_testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PB = 12;
    logic           i_clock, i_reset, i_xfer_req, i_xfer_write, i_xfer_long, slow, bad;
    logic           i_upper_addr_user_mode, i_word_addr_timing_mode, i_virtual_mode;
    logic [3:0]     i_xfer_func, i_upper_addr_user_value, i_host_byte_parity, beats;
    logic [27:2]    i_xfer_addr;
    logic [31:0]    i_wr_data, i_host_addr_data, o_rd_data, o_host_addr_data;
    logic [27-PB:0] i_page_frame;
    logic           o_xfer_busy, o_xfer_done, o_wr_data_take, o_rd_valid, o_rd_parity_err;
    logic           o_host_bus_request, i_host_bus_grant, i_host_bus_acknowledge;
    logic           o_host_addr_strobe, o_host_addr_strobe_oe, o_host_addr_data_oe;
    logic [3:0]     o_host_byte_parity;
    logic           o_host_byte_parity_oe, o_host_word_addr_oe;
    logic [25:0]    o_host_word_addr;
    int             failures = 0, n_compared = 0, cycles = 0, n_take, n_rd, n_err;
    logic           strobe_q = 1'b0;
    logic [26:0]    addr_wa = '0;

    hbm_host_bus_master #(.PAGE_BITS(PB)) dut_u (.*);
    hbm_host_model host_u (.i_clock, .i_reset, .i_req(o_host_bus_request),
        .i_strobe(o_host_addr_strobe), .i_strobe_oe(o_host_addr_strobe_oe),
        .i_ad(o_host_addr_data), .i_wa(o_host_word_addr), .i_beats(beats), .i_slow(slow),
        .i_bad(bad), .o_grant(i_host_bus_grant), .o_ack(i_host_bus_acknowledge),
        .o_ad(i_host_addr_data), .o_par(i_host_byte_parity));

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        i_clock = 0;
        forever #50 i_clock = ~i_clock;
    end
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            failures++;
            conclude();
        end
    end
    always @(posedge i_clock)
    begin
        if (o_host_addr_data_oe)
            check("parity", o_host_byte_parity, host_u.par4(o_host_addr_data));
        if (o_host_addr_data_oe && !i_host_bus_grant)
            check("driven ungranted", 1, 0);
        if (o_host_addr_strobe_oe && !o_host_addr_strobe)
            check("recovery word addr", o_host_word_addr, 0);
        n_take += o_wr_data_take;
        // word pins as they stand in the address phase
        if (o_host_addr_strobe && !strobe_q)
            addr_wa = {o_host_word_addr_oe, o_host_word_addr};
        strobe_q = o_host_addr_strobe;
        if (o_rd_valid)
        begin
            check("read word", o_rd_data, 32'ha5a5_0000 + n_rd);
            n_rd++;
            n_err += o_rd_parity_err;
        end
    end
    // next write word follows each accepted beat
    always @(negedge i_clock) if (o_wr_data_take) i_wr_data <= i_wr_data + 1;

    task automatic xfer(input logic w, lng, input logic [3:0] f, input logic [27:2] a);
        int k;
        @(negedge i_clock);
        {i_xfer_write, i_xfer_long, i_xfer_func, i_xfer_addr} = {w, lng, f, a};
        beats = lng ? 4'h8 : 4'h4;
        i_wr_data = 32'h1000_0000;
        n_take = 0;
        n_rd = 0;
        n_err = 0;
        i_xfer_req = 1;
        @(negedge i_clock);
        check("busy", {31'h0, o_xfer_busy}, 1);
        i_xfer_req = 0;
        for (k = 0; k < 300 && o_xfer_done !== 1'b1; k++) @(negedge i_clock);
        check("done", {31'h0, o_xfer_done}, 1);
        check("idle", {31'h0, o_xfer_busy}, 0);
        check("released", {o_host_addr_data_oe, o_host_byte_parity_oe,
            o_host_word_addr_oe, o_host_addr_strobe_oe}, 0);
    endtask
    task automatic s_write_codes;
        logic [27:2] a;
        for (int f = 0; f < 16; f++)
        begin
            a = {f[3:0], 22'h2a_bcd0};
            xfer(1, 0, f[3:0], a);
            check("addr phase", host_u.addr_cap, {f[3:0], a, 2'b00});
            check("word pins early", {31'h0, addr_wa[26]}, 0);
            check("write beats", n_take, 4);
            for (int k = 0; k < 4; k++)
            begin
                check("write word", host_u.wr_log[k], 32'h1000_0000 + k);
                check("word addr", {6'h0, host_u.wa_log[k]}, {6'h0, a + k[25:0]});
            end
        end
    endtask
    task automatic s_read_long;
        logic [27:2] a;
        a = 26'h155_5550;
        {i_upper_addr_user_mode, i_upper_addr_user_value, i_virtual_mode} = {1'b1, 4'h9, 1'b1};
        i_word_addr_timing_mode = 1;
        slow = 1;
        xfer(0, 1, 4'h3, a);
        check("user addr", host_u.addr_cap, {4'h9, i_page_frame, a[PB-1:2], 2'b00});
        check("read beats", n_rd, 8);
        check("word pins early", addr_wa, {1'b1, i_page_frame, a[PB-1:2]});
        check("parity flags", n_err, 0);
    endtask
    task automatic s_bad_parity;
        bad = 1;
        slow = 0;
        xfer(0, 0, 4'hf, 26'h3ff_fffc);
        check("parity flags", n_err, 4);
        bad = 0;
    endtask
    initial
    begin
        {i_xfer_req, i_xfer_write, i_xfer_long, i_xfer_func, i_xfer_addr, i_wr_data} = '0;
        {i_upper_addr_user_mode, i_upper_addr_user_value, i_word_addr_timing_mode} = '0;
        {i_virtual_mode, slow, bad, beats} = '0;
        i_page_frame = 16'h1234;
        i_reset = 1;
        repeat (4) @(negedge i_clock);
        i_reset = 0;
        s_write_codes();
        s_read_long();
        s_bad_parity();
        conclude();
    end
endmodule // testbench
